// >>> hdl/bit_exec_pkg.sv
// Shared constants and types for the bit, shift and flag execution unit.
// Assumes an 8-bit register file, a 32-entry low I/O space and one clock.
`default_nettype none

package bit_exec_pkg;

  localparam int DATA_W     = 8;
  localparam int SEL_W      = 3;
  localparam int REG_ADDR_W = 5;
  localparam int IO_ADDR_W  = 5;
  localparam int BASE_W     = 2;
  localparam int CNT_W      = 3;

  // Bit positions inside the status flags register.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam int MSB_POS    = 7;
  localparam int HALF_POS   = 3;

  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE     = 8'h01;

  // Least extra cycles of a data access through the memory controller.
  localparam logic [CNT_W-1:0] NVM_EXTRA_CYCLES = 3'h1;
  localparam logic [CNT_W-1:0] ONE_CYCLE        = 3'h1;
  localparam logic [CNT_W-1:0] ZERO_CYCLE       = 3'h0;

  typedef enum logic [5:0] {
    op_idle_instruction,
    op_logical_left_shift,
    op_logical_right_shift,
    op_rotate_left_carry,
    op_rotate_right_carry,
    op_arith_right_shift,
    op_nibble_swap,
    op_io_bit_set,
    op_io_bit_clear,
    op_bit_to_transfer_flag,
    op_transfer_flag_to_bit,
    op_status_bit_set,
    op_status_bit_clear,
    op_carry_set,
    op_carry_clear,
    op_negative_set,
    op_negative_clear,
    op_zero_set,
    op_zero_clear,
    op_global_irq_on,
    op_global_irq_off,
    op_sign_set,
    op_sign_clear,
    op_overflow_set,
    op_overflow_clear,
    op_transfer_set,
    op_transfer_clear,
    op_half_set,
    op_half_clear,
    op_breakpoint,
    op_sleep_entry,
    op_watchdog_restart_op,
    op_data_access
  } op_t;

  typedef enum logic [0:0] {
    st_idle     = 1'b0,
    st_mem_wait = 1'b1
  } seq_state_t;

  // Total cycles of a data access; a base of zero counts as one.
  function automatic logic [CNT_W-1:0] access_cycles(
    input logic [BASE_W-1:0] base,
    input logic              via_nvm
  );
    logic [CNT_W-1:0] total;
    total = (base == '0) ? ONE_CYCLE : {1'b0, base};
    if (via_nvm) begin
      total = total + NVM_EXTRA_CYCLES;
    end
    return total;
  endfunction : access_cycles

endpackage : bit_exec_pkg

`default_nettype wire

// >>> hdl/access_wait_counter.sv
// Counts the cycles of a multi-cycle data access and flags its last one.
// Assumes start is a one-cycle pulse taken only while no access runs.
`default_nettype none

module access_wait_counter (
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  input  wire logic                           start,
  input  wire logic [bit_exec_pkg::BASE_W-1:0] base_cycles,
  input  wire logic                           via_nvm,
  input  wire logic                           nvm_busy,
  input  wire logic                           other_master_active,
  output var  logic                           finish
);

  logic [bit_exec_pkg::CNT_W-1:0] count;
  logic                           active;
  logic                           nvm_path;
  logic                           hold;

  // Contention only stretches accesses through the memory controller.
  assign hold = nvm_path & (nvm_busy | other_master_active);

  always_comb begin
    finish = active & (count == bit_exec_pkg::ONE_CYCLE) & ~hold;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count    <= bit_exec_pkg::ZERO_CYCLE;
      active   <= 1'b0;
      nvm_path <= 1'b0;
    end else if (start) begin
      count    <= bit_exec_pkg::access_cycles(base_cycles, via_nvm)
                  - bit_exec_pkg::ONE_CYCLE;
      active   <= 1'b1;
      nvm_path <= via_nvm;
    end else if (finish) begin
      active   <= 1'b0;
      nvm_path <= 1'b0;
    end else if (active && count != bit_exec_pkg::ONE_CYCLE) begin
      count <= count - bit_exec_pkg::ONE_CYCLE;
    end
  end

endmodule : access_wait_counter

`default_nettype wire

// >>> hdl/bit_shift_flag_exec_unit.sv
// Execution unit for shifts, rotates, nibble swap, I/O bit set and clear,
// transfer-flag moves, status flag operations and core control operations.
// Assumes the decoder presents the operand values read from the register
// file and the I/O space in the same cycle as op_valid.
`default_nettype none

module bit_shift_flag_exec_unit (
  input  wire logic                               clock,
  input  wire logic                               resetn,
  input  wire logic                               op_valid,
  input  wire bit_exec_pkg::op_t                  op_code,
  input  wire logic [bit_exec_pkg::DATA_W-1:0]     reg_data,
  input  wire logic [bit_exec_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [bit_exec_pkg::DATA_W-1:0]     io_data,
  input  wire logic [bit_exec_pkg::IO_ADDR_W-1:0]  io_addr,
  input  wire logic [bit_exec_pkg::SEL_W-1:0]      bit_sel,
  input  wire logic [bit_exec_pkg::BASE_W-1:0]     mem_base_cycles,
  input  wire logic                               mem_via_nvm,
  input  wire logic                               nvm_busy,
  input  wire logic                               other_master_active,
  output var  logic                               ready,
  output var  logic                               op_done,
  output var  logic                               reg_wr_en,
  output var  logic [bit_exec_pkg::REG_ADDR_W-1:0] reg_wr_addr,
  output var  logic [bit_exec_pkg::DATA_W-1:0]     reg_wr_data,
  output var  logic                               io_wr_en,
  output var  logic [bit_exec_pkg::IO_ADDR_W-1:0]  io_wr_addr,
  output var  logic [bit_exec_pkg::DATA_W-1:0]     io_wr_data,
  output var  logic [bit_exec_pkg::DATA_W-1:0]     status_flags_register,
  output var  logic                               break_req,
  output var  logic                               sleep_req,
  output var  logic                               watchdog_restart
);

  logic                           rst_meta;
  logic                           rst_sync;
  logic                           accept;
  logic                           mem_start;
  logic                           mem_finish;
  logic                           next_ready;
  logic                           next_reg_wr;
  logic                           next_io_wr;
  logic                           next_break;
  logic                           next_sleep;
  logic                           next_wdr;
  logic [bit_exec_pkg::DATA_W-1:0] next_status;
  logic [bit_exec_pkg::DATA_W-1:0] next_result;
  logic [bit_exec_pkg::DATA_W-1:0] next_io;
  bit_exec_pkg::seq_state_t        state;
  bit_exec_pkg::seq_state_t        next_state;

  // One-hot mask for a bit position.
  function automatic logic [bit_exec_pkg::DATA_W-1:0] bit_mask(
    input logic [bit_exec_pkg::SEL_W-1:0] pos
  );
    return bit_exec_pkg::ONE_BYTE << pos;
  endfunction : bit_mask

  // Flag update shared by every shift and rotate.
  function automatic logic [bit_exec_pkg::DATA_W-1:0] shift_flags(
    input logic [bit_exec_pkg::DATA_W-1:0] res,
    input logic                            carry,
    input logic                            half,
    input logic                            use_half
  );
    logic [bit_exec_pkg::DATA_W-1:0] f;
    logic                            ovf;
    f   = status_flags_register;
    ovf = res[bit_exec_pkg::MSB_POS] ^ carry;
    f[bit_exec_pkg::FLAG_C] = carry;
    f[bit_exec_pkg::FLAG_Z] = (res == bit_exec_pkg::ZERO_BYTE);
    f[bit_exec_pkg::FLAG_N] = res[bit_exec_pkg::MSB_POS];
    f[bit_exec_pkg::FLAG_V] = ovf;
    f[bit_exec_pkg::FLAG_S] = res[bit_exec_pkg::MSB_POS] ^ ovf;
    if (use_half) begin
      f[bit_exec_pkg::FLAG_H] = half;
    end
    return f;
  endfunction : shift_flags

  // Status bit of a dedicated flag operation; -1 for any other code.
  function automatic int flag_pos(input bit_exec_pkg::op_t op);
    case (op)
      bit_exec_pkg::op_carry_set, bit_exec_pkg::op_carry_clear:
        return bit_exec_pkg::FLAG_C;
      bit_exec_pkg::op_negative_set, bit_exec_pkg::op_negative_clear:
        return bit_exec_pkg::FLAG_N;
      bit_exec_pkg::op_zero_set, bit_exec_pkg::op_zero_clear:
        return bit_exec_pkg::FLAG_Z;
      bit_exec_pkg::op_global_irq_on, bit_exec_pkg::op_global_irq_off:
        return bit_exec_pkg::FLAG_I;
      bit_exec_pkg::op_sign_set, bit_exec_pkg::op_sign_clear:
        return bit_exec_pkg::FLAG_S;
      bit_exec_pkg::op_overflow_set, bit_exec_pkg::op_overflow_clear:
        return bit_exec_pkg::FLAG_V;
      bit_exec_pkg::op_transfer_set, bit_exec_pkg::op_transfer_clear:
        return bit_exec_pkg::FLAG_T;
      bit_exec_pkg::op_half_set, bit_exec_pkg::op_half_clear:
        return bit_exec_pkg::FLAG_H;
      default: return -1;
    endcase
  endfunction : flag_pos

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Requests are only taken while no data access is still running.
  assign accept = op_valid & ready;

  always_comb begin
    next_status = status_flags_register;
    next_result = reg_data;
    next_io     = io_data;
    next_reg_wr = 1'b0;
    next_io_wr  = 1'b0;
    next_break  = 1'b0;
    next_sleep  = 1'b0;
    next_wdr    = 1'b0;
    mem_start   = 1'b0;
    if (accept) begin
      case (op_code)
        bit_exec_pkg::op_logical_left_shift: begin
          next_result = {reg_data[6:0], 1'b0};
          next_status = shift_flags(next_result, reg_data[bit_exec_pkg::MSB_POS],
                                    reg_data[bit_exec_pkg::HALF_POS], 1'b1);
          next_reg_wr = 1'b1;
        end
        bit_exec_pkg::op_logical_right_shift: begin
          next_result = {1'b0, reg_data[7:1]};
          next_status = shift_flags(next_result, reg_data[0], 1'b0, 1'b0);
          next_reg_wr = 1'b1;
        end
        bit_exec_pkg::op_rotate_left_carry: begin
          next_result = {reg_data[6:0],
                         status_flags_register[bit_exec_pkg::FLAG_C]};
          next_status = shift_flags(next_result, reg_data[bit_exec_pkg::MSB_POS],
                                    reg_data[bit_exec_pkg::HALF_POS], 1'b1);
          next_reg_wr = 1'b1;
        end
        bit_exec_pkg::op_rotate_right_carry: begin
          next_result = {status_flags_register[bit_exec_pkg::FLAG_C],
                         reg_data[7:1]};
          next_status = shift_flags(next_result, reg_data[0], 1'b0, 1'b0);
          next_reg_wr = 1'b1;
        end
        bit_exec_pkg::op_arith_right_shift: begin
          next_result = {reg_data[bit_exec_pkg::MSB_POS], reg_data[7:1]};
          next_status = shift_flags(next_result, reg_data[0], 1'b0, 1'b0);
          next_reg_wr = 1'b1;
        end
        bit_exec_pkg::op_nibble_swap: begin
          next_result = {reg_data[3:0], reg_data[7:4]};
          next_reg_wr = 1'b1;
        end
        bit_exec_pkg::op_io_bit_set: begin
          next_io    = io_data | bit_mask(bit_sel);
          next_io_wr = 1'b1;
        end
        bit_exec_pkg::op_io_bit_clear: begin
          next_io    = io_data & ~bit_mask(bit_sel);
          next_io_wr = 1'b1;
        end
        bit_exec_pkg::op_bit_to_transfer_flag: begin
          next_status[bit_exec_pkg::FLAG_T] = reg_data[bit_sel];
        end
        bit_exec_pkg::op_transfer_flag_to_bit: begin
          if (status_flags_register[bit_exec_pkg::FLAG_T]) begin
            next_result = reg_data | bit_mask(bit_sel);
          end else begin
            next_result = reg_data & ~bit_mask(bit_sel);
          end
          next_reg_wr = 1'b1;
        end
        bit_exec_pkg::op_status_bit_set: begin
          next_status[bit_sel] = 1'b1;
        end
        bit_exec_pkg::op_status_bit_clear: begin
          next_status[bit_sel] = 1'b0;
        end
        bit_exec_pkg::op_breakpoint: begin
          next_break = 1'b1;
        end
        bit_exec_pkg::op_sleep_entry: begin
          next_sleep = 1'b1;
        end
        bit_exec_pkg::op_watchdog_restart_op: begin
          next_wdr = 1'b1;
        end
        bit_exec_pkg::op_data_access: begin
          mem_start = (bit_exec_pkg::access_cycles(mem_base_cycles,
                                                   mem_via_nvm)
                       != bit_exec_pkg::ONE_CYCLE);
        end
        default: begin
          if (flag_pos(op_code) >= 0) begin
            next_status[flag_pos(op_code)] = op_code inside {
              bit_exec_pkg::op_carry_set, bit_exec_pkg::op_negative_set,
              bit_exec_pkg::op_zero_set, bit_exec_pkg::op_global_irq_on,
              bit_exec_pkg::op_sign_set, bit_exec_pkg::op_overflow_set,
              bit_exec_pkg::op_transfer_set, bit_exec_pkg::op_half_set};
          end
        end
      endcase
    end
  end

  always_comb begin
    next_state = state;
    next_ready = ready;
    case (state)
      bit_exec_pkg::st_idle: begin
        next_ready = ~mem_start;
        if (mem_start) begin
          next_state = bit_exec_pkg::st_mem_wait;
        end
      end
      bit_exec_pkg::st_mem_wait: begin
        next_ready = mem_finish;
        if (mem_finish) begin
          next_state = bit_exec_pkg::st_idle;
        end
      end
      default: begin
        next_state = bit_exec_pkg::st_idle;
        next_ready = 1'b1;
      end
    endcase
  end

  access_wait_counter wait_counter (
    .clock               (clock),
    .rst_n               (rst_sync),
    .start               (mem_start),
    .base_cycles         (mem_base_cycles),
    .via_nvm             (mem_via_nvm),
    .nvm_busy            (nvm_busy),
    .other_master_active (other_master_active),
    .finish              (mem_finish)
  );

  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      state   <= bit_exec_pkg::st_idle;
      ready   <= 1'b0;
      op_done <= 1'b0;
    end else begin
      state   <= next_state;
      ready   <= next_ready;
      op_done <= (accept & ~mem_start) | mem_finish;
    end
  end

  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      status_flags_register <= bit_exec_pkg::STATUS_RESET;
    end else begin
      status_flags_register <= next_status;
    end
  end

  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_wr_en   <= 1'b0;
      reg_wr_addr <= '0;
      reg_wr_data <= bit_exec_pkg::ZERO_BYTE;
    end else begin
      reg_wr_en <= next_reg_wr;
      if (next_reg_wr) begin
        reg_wr_addr <= reg_addr;
        reg_wr_data <= next_result;
      end
    end
  end

  // Read-modify-write of I/O is done here so other bits stay intact.
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      io_wr_en   <= 1'b0;
      io_wr_addr <= '0;
      io_wr_data <= bit_exec_pkg::ZERO_BYTE;
    end else begin
      io_wr_en <= next_io_wr;
      if (next_io_wr) begin
        io_wr_addr <= io_addr;
        io_wr_data <= next_io;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      break_req        <= 1'b0;
      sleep_req        <= 1'b0;
      watchdog_restart <= 1'b0;
    end else begin
      break_req        <= next_break;
      sleep_req        <= next_sleep;
      watchdog_restart <= next_wdr;
    end
  end

endmodule : bit_shift_flag_exec_unit

`default_nettype wire

// >>> test/bit_shift_flag_exec_unit_chk.sv
// Port checker for the bit, shift and flag execution unit.
// Sees only the unit's ports; attached by the bind below the module.
`default_nettype none

module exec_unit_chk (
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic              op_valid,
  input wire bit_exec_pkg::op_t op_code,
  input wire logic [7:0]        reg_data,
  input wire logic [7:0]        io_data,
  input wire logic [2:0]        bit_sel,
  input wire logic              mem_via_nvm,
  input wire logic              ready,
  input wire logic              op_done,
  input wire logic              reg_wr_en,
  input wire logic [7:0]        reg_wr_data,
  input wire logic              io_wr_en,
  input wire logic [7:0]        io_wr_data,
  input wire logic [7:0]        status_flags_register,
  input wire logic              break_req,
  input wire logic              sleep_req,
  input wire logic              watchdog_restart
);
  wire logic [7:0] st = status_flags_register;
  wire logic       cy = st[bit_exec_pkg::FLAG_C];

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_take(bit_exec_pkg::op_t o);
    op_valid && ready && op_code == o;
  endsequence

  property p_shl;
    s_take(bit_exec_pkg::op_logical_left_shift) |=> reg_wr_en && op_done &&
      reg_wr_data == {$past(reg_data[6:0]), 1'b0} && cy == $past(reg_data[7])
      && st[bit_exec_pkg::FLAG_H] == $past(reg_data[3]);
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");
  property p_rol;
    s_take(bit_exec_pkg::op_rotate_left_carry) |=> reg_wr_en &&
      reg_wr_data == {$past(reg_data[6:0]), $past(cy)};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");
  // The sign bit must survive; a plain right shift would clear it.
  property p_asr;
    s_take(bit_exec_pkg::op_arith_right_shift) |=> reg_wr_en &&
      reg_wr_data == $past({reg_data[7], reg_data[7:1]}) &&
      cy == $past(reg_data[0]);
  endproperty
  a_asr: assert property (p_asr) else $error("arith shift wrong");
  property p_swap;
    s_take(bit_exec_pkg::op_nibble_swap) |=> reg_wr_en && $stable(st) &&
      reg_wr_data == $past({reg_data[3:0], reg_data[7:4]});
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_ioset;
    s_take(bit_exec_pkg::op_io_bit_set) |=> io_wr_en && $stable(st) &&
      io_wr_data == ($past(io_data) | (8'h01 << $past(bit_sel)));
  endproperty
  a_ioset: assert property (p_ioset) else $error("io set wrong");
  property p_ioclr;
    s_take(bit_exec_pkg::op_io_bit_clear) |=> io_wr_en && $stable(st) &&
      io_wr_data == ($past(io_data) & ~(8'h01 << $past(bit_sel)));
  endproperty
  a_ioclr: assert property (p_ioclr) else $error("io clear wrong");
  property p_bst;
    s_take(bit_exec_pkg::op_bit_to_transfer_flag) |=> op_done &&
      st[bit_exec_pkg::FLAG_T] == $past(reg_data[bit_sel]);
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong");
  property p_sset;
    s_take(bit_exec_pkg::op_status_bit_set) |=>
      st == ($past(st) | (8'h01 << $past(bit_sel)));
  endproperty
  a_sset: assert property (p_sset) else $error("flag set wrong");
  property p_brk;
    s_take(bit_exec_pkg::op_breakpoint) |=> break_req && op_done &&
      !sleep_req && $stable(st);
  endproperty
  a_brk: assert property (p_brk) else $error("break wrong");
  property p_idle;
    s_take(bit_exec_pkg::op_idle_instruction) |=> op_done && !reg_wr_en &&
      !io_wr_en && !watchdog_restart && $stable(st);
  endproperty
  a_idle: assert property (p_idle) else $error("idle wrong");
  // A routed access can never finish in the cycle after its take.
  property p_nvm;
    s_take(bit_exec_pkg::op_data_access) ##0 mem_via_nvm |=> !op_done && !ready;
  endproperty
  a_nvm: assert property (p_nvm) else $error("access too short");
endmodule : exec_unit_chk

bind bit_shift_flag_exec_unit exec_unit_chk u_chk (.*);

`default_nettype wire

// >>> test/exec_far_side.sv
// Far-side model: register file and low I/O space beside the unit.
// Assumes write strobes are one-cycle pulses on the core clock.
`default_nettype none

module exec_far_side (
  input  wire logic       clock,
  input  wire logic [4:0] reg_addr,
  input  wire logic [4:0] io_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [4:0] reg_wr_addr,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       io_wr_en,
  input  wire logic [4:0] io_wr_addr,
  input  wire logic [7:0] io_wr_data,
  output var  logic [7:0] reg_data,
  output var  logic [7:0] io_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [32];
  logic [7:0] io_space [32];

  initial begin
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'(i);
      io_space[i] = ~8'(i);
    end
  end
  assign reg_data = regs[reg_addr];
  assign io_data = io_space[io_addr];
  // Writes land at the edge after the strobe, as a register file would.
  always @(posedge clock) begin
    if (reg_wr_en) regs[reg_wr_addr] <= reg_wr_data;
    if (io_wr_en) io_space[io_wr_addr] <= io_wr_data;
  end
endmodule : exec_far_side

`default_nettype wire

// >>> test/test_bit_shift_flag_exec_unit.sv
// Self-checking bench for the bit, shift and flag execution unit.
// Assumes the far-side model stands in for register file and I/O space.
`default_nettype none

module test_bit_shift_flag_exec_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock, resetn, op_valid, mem_via_nvm, nvm_busy;
  logic              other_master_active, ready, op_done, reg_wr_en;
  logic              io_wr_en, break_req, sleep_req, watchdog_restart;
  bit_exec_pkg::op_t op_code;
  logic [7:0]        reg_data, io_data, reg_wr_data, io_wr_data, status, exp_st;
  logic [4:0]        reg_addr, io_addr, reg_wr_addr, io_wr_addr;
  logic [2:0]        bit_sel;
  logic [1:0]        mem_base_cycles;
  int                err_total, n_tests, stall_exp, i;
  int fmap [8] = '{bit_exec_pkg::FLAG_C, bit_exec_pkg::FLAG_N,
    bit_exec_pkg::FLAG_Z, bit_exec_pkg::FLAG_I, bit_exec_pkg::FLAG_S,
    bit_exec_pkg::FLAG_V, bit_exec_pkg::FLAG_T, bit_exec_pkg::FLAG_H};
  bit_exec_pkg::op_t ctl [5] = '{bit_exec_pkg::op_idle_instruction,
    bit_exec_pkg::op_breakpoint, bit_exec_pkg::op_sleep_entry,
    bit_exec_pkg::op_watchdog_restart_op, bit_exec_pkg::op_t'(6'h3f)};

  bit_shift_flag_exec_unit u_dut (.*, .status_flags_register(status));
  exec_far_side u_far (.*);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic shf(input logic [7:0] r, input logic cy, h, use_h);
    exp_st[bit_exec_pkg::FLAG_C] = cy;
    exp_st[bit_exec_pkg::FLAG_Z] = (r == 8'h00);
    exp_st[bit_exec_pkg::FLAG_N] = r[7];
    exp_st[bit_exec_pkg::FLAG_V] = r[7] ^ cy;
    exp_st[bit_exec_pkg::FLAG_S] = r[7] ^ (r[7] ^ cy);
    if (use_h) exp_st[bit_exec_pkg::FLAG_H] = h;
  endtask : shf

  // Issues one operation, waits for completion and checks every result.
  task automatic run(input bit_exec_pkg::op_t op, input logic [4:0] ra,
                     input logic [4:0] ia, input logic [2:0] sel);
    logic [7:0] d, io, r, pulses;
    logic       c, lft;
    int         k, lat, t;
    @(posedge clock);
    #1;
    d = u_far.regs[ra];
    io = u_far.io_space[ia];
    r = d;
    c = exp_st[bit_exec_pkg::FLAG_C];
    pulses = 8'h00;
    t = 0;
    op_valid = 1'b1;
    op_code = op;
    reg_addr = ra;
    io_addr = ia;
    bit_sel = sel;
    for (k = 0; k < 20 && ready !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    op_valid = 1'b0;
    for (lat = 0; lat < 20 && op_done !== 1'b1; lat++) begin
      @(posedge clock);
      #1;
    end
    if (k == 20 || lat == 20) begin
      err_total++;
      conclude();
    end
    case (op)
      bit_exec_pkg::op_logical_left_shift: r = {d[6:0], 1'b0};
      bit_exec_pkg::op_logical_right_shift: r = {1'b0, d[7:1]};
      bit_exec_pkg::op_rotate_left_carry: r = {d[6:0], c};
      bit_exec_pkg::op_rotate_right_carry: r = {c, d[7:1]};
      bit_exec_pkg::op_arith_right_shift: r = {d[7], d[7:1]};
      bit_exec_pkg::op_nibble_swap: r = {d[3:0], d[7:4]};
      bit_exec_pkg::op_io_bit_set: io[sel] = 1'b1;
      bit_exec_pkg::op_io_bit_clear: io[sel] = 1'b0;
      bit_exec_pkg::op_bit_to_transfer_flag: exp_st[bit_exec_pkg::FLAG_T] = d[sel];
      bit_exec_pkg::op_transfer_flag_to_bit: r[sel] = exp_st[bit_exec_pkg::FLAG_T];
      bit_exec_pkg::op_status_bit_set: exp_st[sel] = 1'b1;
      bit_exec_pkg::op_status_bit_clear: exp_st[sel] = 1'b0;
      bit_exec_pkg::op_breakpoint: pulses = 8'h10;
      bit_exec_pkg::op_sleep_entry: pulses = 8'h08;
      bit_exec_pkg::op_watchdog_restart_op: pulses = 8'h04;
      bit_exec_pkg::op_data_access: t = (mem_base_cycles == 2'h0 ? 1 :
        int'(mem_base_cycles)) + int'(mem_via_nvm) - 1 + stall_exp;
      default: if (op >= bit_exec_pkg::op_carry_set &&
                   op <= bit_exec_pkg::op_half_clear)
        exp_st[fmap[(int'(op) - 13) / 2]] = (int'(op) % 2 == 1);
    endcase
    lft = (op == bit_exec_pkg::op_logical_left_shift ||
           op == bit_exec_pkg::op_rotate_left_carry);
    if (op >= bit_exec_pkg::op_logical_left_shift &&
        op <= bit_exec_pkg::op_arith_right_shift)
      shf(r, lft ? d[7] : d[0], d[3], lft);
    if (op >= bit_exec_pkg::op_logical_left_shift &&
        op <= bit_exec_pkg::op_nibble_swap) pulses = 8'h02;
    if (op == bit_exec_pkg::op_transfer_flag_to_bit) pulses = 8'h02;
    if (op inside {bit_exec_pkg::op_io_bit_set, bit_exec_pkg::op_io_bit_clear})
      pulses = 8'h01;
    chk_byte(8'(lat), 8'(t));
    if (op != bit_exec_pkg::op_data_access) chk_byte({3'h0, break_req,
      sleep_req, watchdog_restart, reg_wr_en, io_wr_en}, pulses);
    if (pulses[1]) chk_byte(reg_wr_data, r);
    if (pulses[1]) chk_byte({3'h0, reg_wr_addr}, {3'h0, ra});
    if (pulses[0]) chk_byte(io_wr_data, io);
    if (pulses[0]) chk_byte({3'h0, io_wr_addr}, {3'h0, ia});
    chk_byte(status, exp_st);
  endtask : run

  task automatic access(input logic [1:0] b, input logic n, o, input int s);
    mem_base_cycles = b;
    mem_via_nvm = n;
    other_master_active = o;
    stall_exp = s;
    fork
      run(bit_exec_pkg::op_data_access, 5'h00, 5'h00, 3'h0);
      if (s > 0) begin
        @(posedge clock);
        #1;
        nvm_busy = 1'b1;
        repeat (s + 1) @(posedge clock);
        #1;
        nvm_busy = 1'b0;
      end
    join
  endtask : access

  initial begin
    {resetn, op_valid, mem_via_nvm, nvm_busy, other_master_active} = 5'h00;
    op_code = bit_exec_pkg::op_idle_instruction;
    {reg_addr, io_addr, bit_sel, mem_base_cycles} = 15'h0000;
    {err_total, n_tests, stall_exp} = 0;
    exp_st = 8'h00;
    repeat (6) @(posedge clock);
    chk_byte({op_done, reg_wr_en, io_wr_en, break_req, 4'h0}, 8'h00);
    chk_byte(status, 8'h00);
    #1 resetn = 1'b1;
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      @(posedge clock);
      #1;
      u_far.regs[1] = 8'h81;
      run(bit_exec_pkg::op_t'(i + 1), 5'h01, 5'h00, 3'h0);
    end
    u_far.regs[2] = 8'h01;
    run(bit_exec_pkg::op_logical_right_shift, 5'h02, 5'h00, 3'h0);
    $display("shift test done");
    for (i = 0; i < 8; i++)
      run((i % 2 == 1) ? bit_exec_pkg::op_io_bit_clear :
          bit_exec_pkg::op_io_bit_set, 5'h00, 5'h04, 3'(i));
    $display("io bit test done");
    for (i = 0; i < 2; i++) begin
      run(bit_exec_pkg::op_bit_to_transfer_flag, 5'h01, 5'h00,
          (i == 0) ? 3'h4 : 3'h7);
      run(bit_exec_pkg::op_transfer_flag_to_bit, 5'h02, 5'h00, 3'h5);
    end
    $display("transfer flag test done");
    for (i = 0; i < 16; i++)
      run((i < 8) ? bit_exec_pkg::op_status_bit_set :
          bit_exec_pkg::op_status_bit_clear, 5'h00, 5'h00, 3'(i));
    for (i = 0; i < 16; i++)
      run(bit_exec_pkg::op_t'(i + 13), 5'h00, 5'h00, 3'h0);
    $display("flag test done");
    for (i = 0; i < 5; i++) run(ctl[i], 5'h03, 5'h03, 3'h0);
    $display("control test done");
    access(2'h0, 1'b0, 1'b0, 0);
    access(2'h2, 1'b0, 1'b1, 0);
    access(2'h1, 1'b1, 1'b0, 0);
    access(2'h3, 1'b1, 1'b0, 0);
    access(2'h1, 1'b1, 1'b0, 2);
    $display("access test done");
    conclude();
  end
endmodule : test_bit_shift_flag_exec_unit

`default_nettype wire
